// *** logic/smb_params.svh ***
/*
 Offsets, field positions and reset values of the shared memory bus master.
 Assumes a 32-bit APB with byte addresses in the low eight bits.
*/
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH

// Register byte offsets
`define SMB_AW            8
`define SMB_OFF_CTRL      8'h00
`define SMB_OFF_ADDR      8'h04
`define SMB_OFF_WDATA     8'h08
`define SMB_OFF_RDATA     8'h0C
`define SMB_OFF_STATUS    8'h10
`define SMB_OFF_IRQ_STAT  8'h14
`define SMB_OFF_IRQ_MASK  8'h18

// Control fields
`define SMB_CTRL_START    0
`define SMB_CTRL_STYLE    1
`define SMB_CTRL_WRITE    2
`define SMB_CTRL_AREA_LO  3
`define SMB_CTRL_AREA_HI  4
`define SMB_CTRL_RESUME   5

// Status fields
`define SMB_ST_BUSY       0
`define SMB_ST_SUSP       1
`define SMB_ST_WIDTH32    2
`define SMB_ST_PARITY     3
`define SMB_ST_LAST_ERR   4
`define SMB_ST_OTHER_REQ  5
`define SMB_ST_OTHER_MST  6

// Interrupt fields
`define SMB_IRQ_W         4
`define SMB_IRQ_DONE      0
`define SMB_IRQ_ACT_FAIL  1
`define SMB_IRQ_FR_ABORT  2
`define SMB_IRQ_BUS_ERR   3

// Reset values
`define SMB_RST_WORD      32'h0000_0000
`define SMB_RST_MASK      4'h0

// Synchronised pin vector: positions and idle levels
`define SMB_PIN_W         9
`define SMB_PIN_READY     0
`define SMB_PIN_ACK_N     1
`define SMB_PIN_BUS_ERROR_N_N    2
`define SMB_PIN_HOLD_ACKNOWLEDGE      3
`define SMB_PIN_BG_N      4
`define SMB_PIN_BR_N      5
`define SMB_PIN_GACK_N    6
`define SMB_PIN_WIDTH     7
`define SMB_PIN_PARITY    8
`define SMB_PIN_IDLE      9'h076

// Host answer latency in cycles
`define SMB_HOST_LAT      4

`endif

// *** logic/smb_pkg.sv ***
/*
 Types and shared functions of the shared memory bus master.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package smb_pkg;

    // Master states, Gray along the cycle path
    typedef enum logic [1:0] {
        smb_st_idle = 2'h0,
        smb_st_req  = 2'h1,
        smb_st_cyc  = 2'h3,
        smb_st_rel  = 2'h2
    } smb_state_t;

    // Target area of a cycle
    typedef enum logic [1:0] {
        smb_area_other = 2'h0,
        smb_area_cfg   = 2'h1,
        smb_area_tx    = 2'h2,
        smb_area_rsv   = 2'h3
    } smb_area_t;

    // Keep the low half only in 16-bit mode
    function automatic logic [31:0] smb_fit(input logic [31:0] d, input logic w32);
        smb_fit = w32 ? d : {16'h0000, d[15:0]};
    endfunction

endpackage

// *** logic/smb_if.sv ***
/*
 Pins between the bus master and the host, arbiter and memory side.
 Assumes both ends share clk; open-drain lines resolve here with a pull-up.
*/
`timescale 1ns/10ps
interface smb_if;
    logic        wr_rd;
    logic        wr_rd_oe;
    logic [31:0] dev_wdata;
    logic        data_oe_lo;
    logic        data_oe_hi;
    logic [31:0] mem_rdata;
    logic        ready;
    logic        transfer_ack_n;
    logic        bus_error_n;
    logic        hold_req;
    logic        hold_acknowledge;
    logic        br_dev_o;
    logic        br_dev_oe;
    logic        br_host_o;
    logic        br_host_oe;
    logic        bus_request_n;
    logic        bus_grant_n;
    logic        gack_dev_o;
    logic        gack_dev_oe;
    logic        gack_host_o;
    logic        gack_host_oe;
    logic        grant_acknowledge_n;
    logic        width_select_strap;
    logic        parity_mode_strap;

    // Wired-low lines
    assign bus_request_n       = ~((br_dev_oe & ~br_dev_o) | (br_host_oe & ~br_host_o));
    assign grant_acknowledge_n = ~((gack_dev_oe & ~gack_dev_o) | (gack_host_oe & ~gack_host_o));

    modport dev (
        output wr_rd, wr_rd_oe, dev_wdata, data_oe_lo, data_oe_hi, hold_req,
               br_dev_o, br_dev_oe, gack_dev_o, gack_dev_oe,
        input  mem_rdata, ready, transfer_ack_n, bus_error_n, hold_acknowledge,
               bus_request_n, bus_grant_n, grant_acknowledge_n,
               width_select_strap, parity_mode_strap
    );
    modport host (
        input  wr_rd, wr_rd_oe, dev_wdata, data_oe_lo, data_oe_hi, hold_req,
               bus_request_n, grant_acknowledge_n,
        output mem_rdata, ready, transfer_ack_n, bus_error_n, hold_acknowledge,
               br_host_o, br_host_oe, bus_grant_n, gack_host_o, gack_host_oe,
               width_select_strap, parity_mode_strap
    );
endinterface

// *** logic/smb_sync.sv ***
/*
 Three-stage pin synchroniser; a bit changes once stages two and three agree.
 Assumes synchronous active-high reset and a constant idle vector.
*/
`timescale 1ns/10ps
module smb_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Pins and clean levels
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] lvl
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            ff1_reg <= RST;
            ff2_reg <= RST;
            ff3_reg <= RST;
        end else begin
            ff1_reg <= pin;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // Accept only agreed bits
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl <= RST;
        end else begin
            lvl <= (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (lvl & (ff2_reg ^ ff3_reg));
        end
    end
endmodule

// *** logic/smb_dev.sv ***
/*
 Shared memory bus master with APB control, in two arbitration styles.
 Assumes bus pins are asynchronous to clk and resolved in smb_if.
*/
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "smb_params.svh"
module smb_dev (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`SMB_AW-1:0]  paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Interrupts
    output logic                     irq,
    output logic                     frame_abort_interrupt,
    // Memory bus
    smb_if.dev                       bus
);
    smb_pkg::smb_state_t         state_reg;
    smb_pkg::smb_state_t         state_next;
    smb_pkg::smb_area_t          op_area_reg;
    logic [`SMB_PIN_W-1:0]       pin_lvl;
    logic                        ack_prev_reg;
    logic                        op_style_reg;
    logic                        op_write_reg;
    logic                        start_reg;
    logic                        susp_reg;
    logic                        last_err_reg;
    logic                        parity_reg;
    logic [31:0]                 ctrl_reg;
    logic [31:0]                 addr_reg;
    logic [31:0]                 wdata_reg;
    logic [31:0]                 rdata_reg;
    logic [`SMB_IRQ_W-1:0]       irq_stat_reg;
    logic [`SMB_IRQ_W-1:0]       irq_mask_reg;
    logic [`SMB_IRQ_W-1:0]       irq_set;
    logic [31:0]                 rd_mux;
    logic                        rd_hit;
    logic                        wr_acc;
    logic                        start_req;
    logic                        ack_fell;
    logic                        term_ok;
    logic                        term_err;
    logic                        term;
    logic                        quiet;
    logic                        w32;

    // Pin synchroniser
    smb_sync #(.W(`SMB_PIN_W), .RST(`SMB_PIN_IDLE)) u_sync (
        .clk (clk),
        .rst (rst),
        .pin ({bus.parity_mode_strap, bus.width_select_strap, bus.grant_acknowledge_n,
               bus.bus_request_n, bus.bus_grant_n, bus.hold_acknowledge,
               bus.bus_error_n, bus.transfer_ack_n, bus.ready}),
        .lvl (pin_lvl)
    );

    assign w32      = pin_lvl[`SMB_PIN_WIDTH];
    assign ack_fell = ack_prev_reg & ~pin_lvl[`SMB_PIN_ACK_N];
    assign term_ok  = op_style_reg ? ack_fell : pin_lvl[`SMB_PIN_READY];
    assign term_err = ~pin_lvl[`SMB_PIN_BUS_ERROR_N_N];
    assign term     = (state_reg == smb_pkg::smb_st_cyc) && (term_ok || term_err);
    assign quiet    = op_style_reg ?
                      (pin_lvl[`SMB_PIN_BG_N] & pin_lvl[`SMB_PIN_ACK_N] & ~term_err) :
                      (~pin_lvl[`SMB_PIN_HOLD_ACKNOWLEDGE] & ~pin_lvl[`SMB_PIN_READY] & ~term_err);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_prev_reg <= 1'b1;
        end else begin
            ack_prev_reg <= pin_lvl[`SMB_PIN_ACK_N];
        end
    end

    // Parity strap follows the pin through reset, frozen after release
    always_ff @(posedge clk) begin
        if (rst) begin
            parity_reg <= bus.parity_mode_strap;
        end
    end

    // Cycle sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            smb_pkg::smb_st_idle: begin
                if (start_reg) begin
                    state_next = smb_pkg::smb_st_req;
                end
            end
            smb_pkg::smb_st_req: begin
                if (op_style_reg) begin
                    if (!pin_lvl[`SMB_PIN_BG_N] && pin_lvl[`SMB_PIN_GACK_N]) begin
                        state_next = smb_pkg::smb_st_cyc;
                    end
                end else if (pin_lvl[`SMB_PIN_HOLD_ACKNOWLEDGE]) begin
                    state_next = smb_pkg::smb_st_cyc;
                end
            end
            smb_pkg::smb_st_cyc: begin
                if (term) begin
                    state_next = smb_pkg::smb_st_rel;
                end
            end
            smb_pkg::smb_st_rel: begin
                if (quiet) begin
                    state_next = smb_pkg::smb_st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= smb_pkg::smb_st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request and acknowledge drives
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.hold_req    <= 1'b0;
            bus.br_dev_o    <= 1'b1;
            bus.br_dev_oe   <= 1'b0;
            bus.gack_dev_o  <= 1'b1;
            bus.gack_dev_oe <= 1'b0;
        end else begin
            bus.hold_req    <= !op_style_reg && (state_next == smb_pkg::smb_st_req ||
                               state_next == smb_pkg::smb_st_cyc);
            bus.br_dev_o    <= 1'b0;
            bus.br_dev_oe   <= op_style_reg && (state_next == smb_pkg::smb_st_req ||
                               state_next == smb_pkg::smb_st_cyc);
            bus.gack_dev_o  <= 1'b0;
            bus.gack_dev_oe <= op_style_reg && (state_next == smb_pkg::smb_st_cyc);
        end
    end

    // Direction and data drives
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.wr_rd      <= 1'b0;
            bus.wr_rd_oe   <= 1'b0;
            bus.dev_wdata  <= `SMB_RST_WORD;
            bus.data_oe_lo <= 1'b0;
            bus.data_oe_hi <= 1'b0;
        end else begin
            bus.wr_rd      <= op_write_reg;
            bus.wr_rd_oe   <= (state_next == smb_pkg::smb_st_cyc);
            bus.dev_wdata  <= smb_pkg::smb_fit(wdata_reg, w32);
            bus.data_oe_lo <= op_write_reg && (state_next == smb_pkg::smb_st_cyc);
            bus.data_oe_hi <= op_write_reg && w32 && (state_next == smb_pkg::smb_st_cyc);
        end
    end

    // Read capture and error outcome
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg    <= `SMB_RST_WORD;
            last_err_reg <= 1'b0;
        end else if (term) begin
            last_err_reg <= term_err;
            if (!op_write_reg && !term_err) begin
                rdata_reg <= smb_pkg::smb_fit(bus.mem_rdata, w32);
            end
        end
    end

    // Interrupt events
    always_comb begin
        irq_set                    = '0;
        irq_set[`SMB_IRQ_DONE]     = term;
        irq_set[`SMB_IRQ_BUS_ERR]  = term && term_err;
        irq_set[`SMB_IRQ_ACT_FAIL] = term && term_err && !op_write_reg &&
                                     op_area_reg == smb_pkg::smb_area_cfg;
        irq_set[`SMB_IRQ_FR_ABORT] = term && term_err && !op_write_reg &&
                                     op_area_reg == smb_pkg::smb_area_tx;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_abort_interrupt <= 1'b0;
        end else begin
            frame_abort_interrupt <= irq_set[`SMB_IRQ_FR_ABORT];
        end
    end

    // Suspended action, resumed by software
    always_ff @(posedge clk) begin
        if (rst) begin
            susp_reg <= 1'b0;
        end else if (irq_set[`SMB_IRQ_ACT_FAIL]) begin
            susp_reg <= 1'b1;
        end else if (wr_acc && paddr == `SMB_OFF_CTRL && pwdata[`SMB_CTRL_RESUME]) begin
            susp_reg <= 1'b0;
        end
    end

    // APB access decode
    assign wr_acc    = psel && penable && pwrite && pready;
    assign start_req = wr_acc && paddr == `SMB_OFF_CTRL && pwdata[`SMB_CTRL_START] &&
                       state_reg == smb_pkg::smb_st_idle && !start_reg &&
                       !(susp_reg && pwdata[`SMB_CTRL_AREA_HI:`SMB_CTRL_AREA_LO] ==
                         smb_pkg::smb_area_cfg);

    // Operation latch at start
    always_ff @(posedge clk) begin
        if (rst) begin
            start_reg    <= 1'b0;
            op_style_reg <= 1'b0;
            op_write_reg <= 1'b0;
            op_area_reg  <= smb_pkg::smb_area_other;
        end else if (start_req) begin
            start_reg    <= 1'b1;
            op_style_reg <= pwdata[`SMB_CTRL_STYLE];
            op_write_reg <= pwdata[`SMB_CTRL_WRITE];
            op_area_reg  <= smb_pkg::smb_area_t'(pwdata[`SMB_CTRL_AREA_HI:`SMB_CTRL_AREA_LO]);
        end else if (state_reg != smb_pkg::smb_st_idle) begin
            start_reg    <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg  <= `SMB_RST_WORD;
            addr_reg  <= `SMB_RST_WORD;
            wdata_reg <= `SMB_RST_WORD;
            irq_mask_reg <= `SMB_RST_MASK;
        end else if (wr_acc) begin
            if (paddr == `SMB_OFF_CTRL) begin
                ctrl_reg <= {26'h0, pwdata[5:0]};
            end
            if (paddr == `SMB_OFF_ADDR) begin
                addr_reg <= pwdata;
            end
            if (paddr == `SMB_OFF_WDATA && state_reg == smb_pkg::smb_st_idle) begin
                wdata_reg <= pwdata;
            end
            if (paddr == `SMB_OFF_IRQ_MASK) begin
                irq_mask_reg <= pwdata[`SMB_IRQ_W-1:0];
            end
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                ~((wr_acc && paddr == `SMB_OFF_IRQ_STAT) ? pwdata[`SMB_IRQ_W-1:0] : '0)) |
                irq_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read mux
    always_comb begin
        rd_mux = `SMB_RST_WORD;
        rd_hit = 1'b1;
        unique case (paddr)
            `SMB_OFF_CTRL:     rd_mux = ctrl_reg;
            `SMB_OFF_ADDR:     rd_mux = addr_reg;
            `SMB_OFF_WDATA:    rd_mux = wdata_reg;
            `SMB_OFF_RDATA:    rd_mux = rdata_reg;
            `SMB_OFF_STATUS: begin
                rd_mux[`SMB_ST_BUSY]      = start_reg || state_reg != smb_pkg::smb_st_idle;
                rd_mux[`SMB_ST_SUSP]      = susp_reg;
                rd_mux[`SMB_ST_WIDTH32]   = w32;
                rd_mux[`SMB_ST_PARITY]    = parity_reg;
                rd_mux[`SMB_ST_LAST_ERR]  = last_err_reg;
                rd_mux[`SMB_ST_OTHER_REQ] = !pin_lvl[`SMB_PIN_BR_N] && !bus.br_dev_oe;
                rd_mux[`SMB_ST_OTHER_MST] = !pin_lvl[`SMB_PIN_GACK_N] && !bus.gack_dev_oe;
            end
            `SMB_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_reg};
            `SMB_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
            default:           rd_hit = 1'b0;
        endcase
    end

    // One wait-free access phase after each setup
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= `SMB_RST_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            if (psel && !penable) begin
                prdata <= rd_mux;
            end
        end
    end
endmodule

// *** logic/smb_host.sv ***
/*
 Host side: processor or arbiter grant logic, board straps and a memory responder.
 Assumes the master shares clk; answers are held until the master releases the cycle.
*/
`timescale 1ns/10ps
`include "smb_params.svh"
module smb_host #(
    parameter int LAT = `SMB_HOST_LAT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Board straps and arbitration style
    input  wire logic        style,
    input  wire logic        strap_width,
    input  wire logic        strap_parity,
    input  wire logic        other_master,
    // Memory contents and error injection
    input  wire logic [31:0] rd_word,
    input  wire logic        err_sel,
    output logic      [31:0] wr_word,
    output logic             wr_strobe,
    output logic             rd_strobe,
    // Bus
    smb_if.host              bus
);
    logic [7:0] cnt_reg;
    logic       answered_reg;
    logic       hit;

    assign hit = bus.wr_rd_oe && !answered_reg && cnt_reg == 8'(LAT);

    // Straps held static by the board
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.width_select_strap <= strap_width;
            bus.parity_mode_strap  <= strap_parity;
        end
    end

    // Arbitration
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.hold_acknowledge <= 1'b0;
            bus.bus_grant_n      <= 1'b1;
            bus.br_host_o        <= 1'b0;
            bus.br_host_oe       <= 1'b0;
            bus.gack_host_o      <= 1'b0;
            bus.gack_host_oe     <= 1'b0;
        end else begin
            bus.hold_acknowledge <= !style && bus.hold_req;
            bus.bus_grant_n      <= !(style && !bus.bus_request_n && !other_master);
            bus.br_host_oe       <= other_master;
            bus.gack_host_oe     <= other_master;
        end
    end

    // Latency count within a cycle
    always_ff @(posedge clk) begin
        if (rst || !bus.wr_rd_oe) begin
            cnt_reg      <= 8'h00;
            answered_reg <= 1'b0;
        end else if (hit) begin
            answered_reg <= 1'b1;
        end else if (!answered_reg) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // Answer held until the master lets go
    always_ff @(posedge clk) begin
        if (rst || !bus.wr_rd_oe) begin
            bus.ready          <= 1'b0;
            bus.transfer_ack_n <= 1'b1;
            bus.bus_error_n    <= 1'b1;
        end else if (hit) begin
            bus.bus_error_n    <= !err_sel;
            bus.ready          <= !err_sel && !style;
            bus.transfer_ack_n <= !(!err_sel && style);
        end
    end

    // Memory data
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.mem_rdata <= 32'h0000_0000;
            wr_word       <= 32'h0000_0000;
            wr_strobe     <= 1'b0;
            rd_strobe     <= 1'b0;
        end else begin
            wr_strobe <= hit && bus.wr_rd && !err_sel;
            rd_strobe <= hit && !bus.wr_rd && !err_sel;
            if (hit && !bus.wr_rd) begin
                bus.mem_rdata <= rd_word;
            end
            if (hit && bus.wr_rd) begin
                wr_word <= {bus.data_oe_hi ? bus.dev_wdata[31:16] : 16'h0000,
                            bus.data_oe_lo ? bus.dev_wdata[15:0] : 16'h0000};
            end
        end
    end
endmodule

// *** verification/smb_checker.sv ***
/* Pin checks between the two bus master ends.
   Assumes one clock, reset synchronous high. */
`timescale 1ns/10ps
module smb_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus pins
    input wire logic wr_rd,
    input wire logic wr_rd_oe,
    input wire logic data_oe_lo,
    input wire logic data_oe_hi,
    input wire logic hold_req,
    input wire logic hold_acknowledge,
    input wire logic br_dev_oe,
    input wire logic gack_dev_oe,
    input wire logic ready,
    input wire logic transfer_ack_n,
    input wire logic bus_error_n,
    input wire logic width_select_strap
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ans; ready || !transfer_ack_n || !bus_error_n; endsequence
    property p_dir; data_oe_lo |-> wr_rd_oe && wr_rd; endproperty
    a_dir: assert property (p_dir) else $error("data off write");
    property p_hiz; wr_rd_oe |-> hold_req || br_dev_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("dir without bus");
    property p_end; wr_rd_oe ##0 s_ans |-> ##[1:8] !wr_rd_oe; endproperty
    a_end: assert property (p_end) else $error("cycle not ended");
    property p_cause; $fell(wr_rd_oe) |-> s_ans; endproperty
    a_cause: assert property (p_cause) else $error("cycle abandoned");
    property p_w16; data_oe_hi |-> width_select_strap; endproperty
    a_w16: assert property (p_w16) else $error("upper half driven");
    property p_hold; $rose(wr_rd_oe) && hold_req |-> hold_acknowledge; endproperty
    a_hold: assert property (p_hold) else $error("cycle before hold");
    property p_gack; $rose(wr_rd_oe) && !hold_req |-> gack_dev_oe; endproperty
    a_gack: assert property (p_gack) else $error("no grant ack");
    property p_req; $fell(hold_req) |-> !wr_rd_oe; endproperty
    a_req: assert property (p_req) else $error("request dropped");
endmodule

// *** verification/shared_memory_bus_master_bench.sv ***
/* Bench: both ends joined, driven over APB.
   Assumes design and checker compiled first. */
`timescale 1ns/10ps
`include "smb_params.svh"
module shared_memory_bus_master_bench;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, fa;
    logic        st, sw, sp, om, es, se, su;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rw, ww, q;
    int          err_count, n_tests, fa_n, i, j;
    smb_if bus ();
    smb_dev smb_dev_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .frame_abort_interrupt(fa), .bus(bus.dev));
    smb_host smb_host_inst (.clk(clk), .rst(rst), .style(st), .strap_width(sw),
        .strap_parity(sp), .other_master(om), .rd_word(rw), .err_sel(es), .wr_word(ww),
        .wr_strobe(), .rd_strobe(), .bus(bus.host));
    smb_checker smb_checker_inst (.clk(clk), .rst(rst), .wr_rd(bus.wr_rd),
        .wr_rd_oe(bus.wr_rd_oe), .data_oe_lo(bus.data_oe_lo), .data_oe_hi(bus.data_oe_hi),
        .hold_req(bus.hold_req), .hold_acknowledge(bus.hold_acknowledge),
        .br_dev_oe(bus.br_dev_oe), .gack_dev_oe(bus.gack_dev_oe), .ready(bus.ready),
        .transfer_ack_n(bus.transfer_ack_n), .bus_error_n(bus.bus_error_n),
        .width_select_strap(bus.width_select_strap));
    task automatic finish_test;
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic hang;
        err_count++;
        finish_test();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) hang();
        {q, se} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(q, e);
    endtask
    task automatic idle;
        int k;
        for (k = 0; k < 100; k++) begin
            apb(1'b0, `SMB_OFF_STATUS, '0);
            if (q[0] === 1'b0) return;
        end
        hang();
    endtask
    task automatic op(input logic s, wr, e, input logic [1:0] ar, input logic [31:0] d);
        logic [31:0] x, f;
        int          n;
        x = {28'h0, e, e & !wr & ar == 2, e & !wr & ar == 1, 1'b1};
        f = sw ? d : {16'h0000, d[15:0]};
        n = fa_n;
        {st, es, rw} <= {s, e, d};
        apb(1'b1, `SMB_OFF_WDATA, d);
        apb(1'b1, `SMB_OFF_IRQ_MASK, {28'h0, d[3:0]});
        apb(1'b1, `SMB_OFF_CTRL, {27'h0, ar, wr, s, 1'b1});
        idle();
        chk(irq, |(x & d[3:0]));
        rdc(`SMB_OFF_IRQ_STAT, x);
        if (!wr && !e) rdc(`SMB_OFF_RDATA, f);
        if (wr && !e) chk(ww, f);
        chk(fa_n - n, e & !wr & ar == 2);
        su = su | (e & !wr & ar == 1);
        rdc(`SMB_OFF_STATUS, {27'h0, e, sp, sw, su, 1'b0});
        apb(1'b1, `SMB_OFF_IRQ_STAT, 32'h0000_000F);
        rdc(`SMB_OFF_IRQ_STAT, '0);
        if (su) begin
            apb(1'b1, `SMB_OFF_CTRL, 32'h0000_0009);
            rdc(`SMB_OFF_STATUS, {27'h0, e, sp, sw, su, 1'b0});
            apb(1'b1, `SMB_OFF_CTRL, 32'h0000_0020);
            su = 1'b0;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (fa === 1'b1) fa_n++;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, st, om, es, su, rw} = '0;
        for (j = 0; j < 2; j++) begin
            {rst, sw, sp} <= {1'b1, j[0], j[0]};
            repeat (5) @(posedge clk);
            rst <= 1'b0;
            repeat (4) @(posedge clk); // Straps settle through the synchroniser
            rdc(`SMB_OFF_STATUS, {28'h0, j[0], j[0], 2'h0});
            for (i = 0; i < 24; i++) op(i[0], i[1], i[2], 2'(i / 8), 32'hA5C3_0F00 + i);
            $display("width test %0d done", j);
        end
        {om, st, es} <= 3'b110;
        repeat (8) @(posedge clk);
        apb(1'b0, `SMB_OFF_STATUS, '0);
        chk(q & 32'h0000_0061, 32'h0000_0060);
        apb(1'b1, `SMB_OFF_CTRL, 32'h0000_0003);
        repeat (40) @(posedge clk);
        apb(1'b0, `SMB_OFF_STATUS, '0);
        chk(q & 32'h0000_0061, 32'h0000_0041);
        apb(1'b1, `SMB_OFF_WDATA, '0);
        rdc(`SMB_OFF_WDATA, 32'hA5C3_0F17);
        om <= 1'b0;
        idle();
        rdc(`SMB_OFF_IRQ_STAT, 32'h0000_0001);
        rdc(`SMB_OFF_RDATA, 32'hA5C3_0F17);
        rdc(`SMB_OFF_CTRL, 32'h0000_0003);
        apb(1'b1, `SMB_OFF_ADDR, 32'h3C5A_96E1);
        rdc(`SMB_OFF_ADDR, 32'h3C5A_96E1);
        apb(1'b1, 8'h1C, '1);
        chk(se, 1'b1);
        rdc(8'h1C, '0);
        chk(se, 1'b1);
        $display("arbitration and map test done");
        finish_test();
    end
endmodule
